// ==== inc/pslm_pkg.sv ====
// Package for the process scaling, tare and limit alarm core.
// Assumes a single 100 MHz clock domain; core, checker, panel model and bench share these types.
`default_nettype none
package pslm_pkg;
  localparam int VAL_W = 24;
  localparam int ADC_W = 16;
  localparam logic [15:0] HIGH_SCALE_MIN = 16'h0001;
  localparam logic [15:0] HIGH_SCALE_MAX = 16'h7530;
  localparam logic [15:0] HIGH_SCALE_RST = 16'h0001;
  localparam logic [15:0] LOW_SCALE_RST = 16'h0000;
  localparam logic [23:0] LIMIT_RST = 24'h000001;
  localparam logic [23:0] ZERO_VAL = 24'h000000;
  localparam int NUM_PROC = 4;
  localparam int NUM_TIMER = 2;
  localparam int NUM_ALARM = 6;
  localparam int TIMER_ONE_IDX = 4;
  localparam int TIMER_TWO_IDX = 5;
  localparam logic [2:0] RESET_IDX = 3'h7;

  // Display positions stepped by the limits key
  typedef enum logic [3:0] {
    PSLM_SHOW_PROCESS = 4'h0,
    PSLM_SHOW_RATE = 4'h1,
    PSLM_SHOW_LIM1 = 4'h2,
    PSLM_SHOW_LIM2 = 4'h3,
    PSLM_SHOW_LIM3 = 4'h4,
    PSLM_SHOW_LIM4 = 4'h5,
    PSLM_SHOW_TMR1 = 4'h6,
    PSLM_SHOW_TMR2 = 4'h7
  } pslm_view_t;

  // Labels driven to the display
  typedef enum logic [3:0] {
    PSLM_LBL_NONE = 4'h0,
    PSLM_LBL_RATE = 4'h1,
    PSLM_LBL_PROC1 = 4'h2,
    PSLM_LBL_PROC2 = 4'h3,
    PSLM_LBL_PROC3 = 4'h4,
    PSLM_LBL_PROC4 = 4'h5,
    PSLM_LBL_RATE_LIMIT = 4'h6,
    PSLM_LBL_DEVIATION = 4'h7,
    PSLM_LBL_TIMER1 = 4'h8,
    PSLM_LBL_TIMER2 = 4'h9,
    PSLM_LBL_RELAY_RESET = 4'ha
  } pslm_label_t;

  // Front keys and remote contact, raw pin levels
  typedef struct packed {
    logic tare_key;
    logic limits_key;
    logic reset_key;
    logic time_key;
    logic remote_contact;
  } pslm_keys_t;

  // Setup configuration
  typedef struct packed {
    logic setup_mode;
    logic remote_tare_option;
    logic lim3_is_rate;
    logic lim4_is_deviation;
    logic [5:0] latching;
    logic [5:0] normally_closed;
  } pslm_cfg_t;

  // Setup write port for scale, offset and tare
  typedef struct packed {
    logic wr_high;
    logic wr_low;
    logic wr_offset;
    logic wr_tare;
    logic [23:0] wdata;
  } pslm_param_wr_t;
endpackage
`default_nettype wire

// ==== rtl/pslm_core.sv ====
// Scaling, offset, tare, limit display and alarm outputs of a process monitor.
// Assumes keys and remote contact are raw pins; sample and limits come from logic on sys_clk.
//
// Function
// R01: Linear map: minimum input gives low scale, full input gives high scale.
// R02: Current loop reads low scale when input equals offset.
// R03: Accept high scale 1..30000 and low scale 0..high scale only.
// R04: Scale and offset viewed or changed only in setup mode.
// R05: Offset makes a chosen nonzero input read zero.
// R06: Displayed value is reading minus stored tare.
// R07: Tare key in setup captures present reading as tare.
// R08: Remote tare captures reading on activation and every update while active.
// R09: Setup option picks remote tare or remote hold.
// R10: Limits key steps rate, limits one to four, timers, label first.
// R11: Limit three as rate, four as deviation show those labels.
// R12: Non-latching alarm drops when process falls below limit.
// R13: Latching alarm stays active until manual reset.
// R14: Limits held plus reset clears shown alarm and shows relay reset.
// R15: In elapsed-time view limits key shows timer one then two.
// R16: Time plus reset clears both timer alarms.
// R17: Alarm activates at limit and lights its indicator.
// R18: Each output normally open or closed, default open.
// R19: Remote hold freezes displayed process value while active.
// R20: Each sample recompute scaled minus offset minus tare, then check limits.
`timescale 1ns/1ns
`default_nettype none
module pslm_core #(
  parameter int LABEL_CYCLES = 16
)(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire pslm_pkg::pslm_keys_t keys,
  input wire pslm_pkg::pslm_cfg_t cfg,
  input wire pslm_pkg::pslm_param_wr_t param_wr,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire logic [15:0] sample_full,
  input wire logic loop_input,
  input wire logic [23:0] rate_value,
  input wire logic [23:0] deviation_value,
  input wire logic [23:0] elapsed_time,
  input wire logic [4*24-1:0] proc_limits,
  input wire logic [2*24-1:0] timer_limits,
  output logic [15:0] high_scale,
  output logic [15:0] low_scale,
  output logic [23:0] offset_value,
  output logic [23:0] tare_value,
  output logic [23:0] process_value,
  output logic [23:0] display_value,
  output var pslm_pkg::pslm_label_t display_label,
  output var pslm_pkg::pslm_view_t view,
  output logic time_view,
  output logic [5:0] alarm_active,
  output logic [5:0] alarm_out,
  output logic [5:0] alarm_led
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pslm_pkg::pslm_keys_t keys_s1;
  pslm_pkg::pslm_keys_t keys_s2;
  pslm_pkg::pslm_keys_t keys_d;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      keys_s1 <= '0;
      keys_s2 <= '0;
      keys_d <= '0;
    end
    else
    begin
      keys_s1 <= keys;
      keys_s2 <= keys_s1;
      keys_d <= keys_s2;
    end
  end

  logic tare_press;
  logic limits_press;
  logic reset_press;
  logic time_press;
  logic remote_rise;
  assign tare_press = keys_s2.tare_key && !keys_d.tare_key;
  assign limits_press = keys_s2.limits_key && !keys_d.limits_key;
  assign reset_press = keys_s2.reset_key && !keys_d.reset_key;
  assign time_press = keys_s2.time_key && !keys_d.time_key;
  assign remote_rise = keys_s2.remote_contact && !keys_d.remote_contact;

  ////////////////////////////////////////////////////////////////////////
  // Setup parameters
  logic [15:0] next_high;
  assign next_high = param_wr.wdata[15:0];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      high_scale <= pslm_pkg::HIGH_SCALE_RST;
      low_scale <= pslm_pkg::LOW_SCALE_RST;
      offset_value <= pslm_pkg::ZERO_VAL;
    end
    // R04: setup only access
    else if (cfg.setup_mode)
    begin
      // R03: range check
      if (param_wr.wr_high && next_high >= pslm_pkg::HIGH_SCALE_MIN
          && next_high <= pslm_pkg::HIGH_SCALE_MAX && next_high >= low_scale)
        high_scale <= next_high;
      // R03: low within high
      if (param_wr.wr_low && param_wr.wdata[15:0] <= high_scale)
        low_scale <= param_wr.wdata[15:0];
      // R05: offset store
      if (param_wr.wr_offset)
        offset_value <= param_wr.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scaling pipeline
  logic [15:0] span_in;
  logic [15:0] above_offset;
  logic [31:0] product;
  logic [23:0] scaled;
  logic [15:0] full_den;
  logic [15:0] zero_point;

  // R02: loop zero at offset
  assign zero_point = loop_input ? offset_value[15:0] : 16'h0000;
  assign above_offset = (sample > zero_point) ? sample - zero_point : 16'h0000;
  assign full_den = (sample_full > zero_point) ? sample_full - zero_point : 16'h0001;
  assign span_in = high_scale - low_scale;
  assign product = above_offset * span_in;

  // R01: linear map
  always_comb
  begin
    scaled = 24'(product / {16'h0000, full_den}) + {8'h00, low_scale};
  end

  logic [23:0] net_value;
  logic [23:0] offset_sub;
  // R05: offset to zero
  assign offset_sub = loop_input ? pslm_pkg::ZERO_VAL : offset_value;
  // R06: net of tare
  assign net_value = scaled - offset_sub - tare_value;

  logic hold_active;
  logic remote_tare_on;
  // R09: remote function select
  assign remote_tare_on = keys_s2.remote_contact && cfg.remote_tare_option;
  assign hold_active = keys_s2.remote_contact && !cfg.remote_tare_option;

  // R20: recompute on sample
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      process_value <= pslm_pkg::ZERO_VAL;
    // R19: hold freezes value
    else if (sample_valid && !hold_active)
      process_value <= net_value;
  end

  logic [23:0] gross_reading;
  assign gross_reading = scaled - offset_sub;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      tare_value <= pslm_pkg::ZERO_VAL;
    // R07: tare key capture
    else if (cfg.setup_mode && tare_press)
      tare_value <= gross_reading;
    // R08: remote tare capture
    else if (remote_tare_on && (remote_rise || sample_valid))
      tare_value <= gross_reading;
    else if (cfg.setup_mode && param_wr.wr_tare)
      tare_value <= param_wr.wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit display stepping
  logic relay_msg;
  logic [7:0] label_cnt;
  logic clear_latch;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      view <= pslm_pkg::PSLM_SHOW_PROCESS;
      time_view <= 1'b0;
    end
    else if (time_press)
    begin
      time_view <= 1'b1;
      view <= pslm_pkg::PSLM_SHOW_PROCESS;
    end
    else if (limits_press)
    begin
      unique case (view)
        // R15: time view to timers
        pslm_pkg::PSLM_SHOW_PROCESS:
          view <= time_view ? pslm_pkg::PSLM_SHOW_TMR1 : pslm_pkg::PSLM_SHOW_RATE;
        // R10: step sequence
        pslm_pkg::PSLM_SHOW_RATE: view <= pslm_pkg::PSLM_SHOW_LIM1;
        pslm_pkg::PSLM_SHOW_LIM1: view <= pslm_pkg::PSLM_SHOW_LIM2;
        pslm_pkg::PSLM_SHOW_LIM2: view <= pslm_pkg::PSLM_SHOW_LIM3;
        pslm_pkg::PSLM_SHOW_LIM3: view <= pslm_pkg::PSLM_SHOW_LIM4;
        pslm_pkg::PSLM_SHOW_LIM4: view <= pslm_pkg::PSLM_SHOW_TMR1;
        pslm_pkg::PSLM_SHOW_TMR1: view <= pslm_pkg::PSLM_SHOW_TMR2;
        pslm_pkg::PSLM_SHOW_TMR2: view <= pslm_pkg::PSLM_SHOW_PROCESS;
        default: view <= pslm_pkg::PSLM_SHOW_PROCESS;
      endcase
      time_view <= 1'b0;
    end
  end

  // Label shown briefly after each step or relay reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      label_cnt <= 8'h00;
    else if (limits_press || time_press || clear_latch)
      label_cnt <= 8'(LABEL_CYCLES);
    else if (label_cnt != 8'h00)
      label_cnt <= label_cnt - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm evaluation
  logic [2:0] shown_idx;
  logic timer_clear;

  always_comb
  begin
    unique case (view)
      pslm_pkg::PSLM_SHOW_LIM1: shown_idx = 3'h0;
      pslm_pkg::PSLM_SHOW_LIM2: shown_idx = 3'h1;
      pslm_pkg::PSLM_SHOW_LIM3: shown_idx = 3'h2;
      pslm_pkg::PSLM_SHOW_LIM4: shown_idx = 3'h3;
      pslm_pkg::PSLM_SHOW_TMR1: shown_idx = 3'(pslm_pkg::TIMER_ONE_IDX);
      pslm_pkg::PSLM_SHOW_TMR2: shown_idx = 3'(pslm_pkg::TIMER_TWO_IDX);
      default: shown_idx = pslm_pkg::RESET_IDX;
    endcase
  end

  // R14: limits held plus reset
  assign clear_latch = keys_s2.limits_key && reset_press && shown_idx != pslm_pkg::RESET_IDX;
  // R16: time plus reset
  assign timer_clear = keys_s2.time_key && reset_press;

  logic [5:0] reached;
  logic [4*24-1:0] watched;
  // R11: rate and deviation sources
  assign watched = {cfg.lim4_is_deviation ? deviation_value : process_value,
    cfg.lim3_is_rate ? rate_value : process_value, process_value, process_value};
  genvar gi;
  generate
    for (gi = 0; gi < pslm_pkg::NUM_PROC; gi++)
    begin : g_proc
      // R17: process limit reached
      assign reached[gi] = $signed(watched[gi*24 +: 24]) >= $signed(proc_limits[gi*24 +: 24]);
    end
    for (gi = 0; gi < pslm_pkg::NUM_TIMER; gi++)
    begin : g_tmr
      assign reached[pslm_pkg::NUM_PROC + gi] = elapsed_time >= timer_limits[gi*24 +: 24];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      alarm_active <= '0;
    else
    begin
      for (int i = 0; i < pslm_pkg::NUM_ALARM; i++)
      begin
        if (i >= pslm_pkg::NUM_PROC && timer_clear)
          alarm_active[i] <= 1'b0;
        // R17: set at limit
        else if (reached[i])
          alarm_active[i] <= 1'b1;
        // R14: manual clear
        else if (clear_latch && 3'(i) == shown_idx)
          alarm_active[i] <= 1'b0;
        // R12: non-latching drop
        // R13: latching hold
        else if (!cfg.latching[i])
          alarm_active[i] <= 1'b0;
      end
    end
  end

  // R18: output polarity
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_out <= '0;
      alarm_led <= '0;
    end
    else
    begin
      alarm_out <= alarm_active ^ cfg.normally_closed;
      // R17: indicator lit
      alarm_led <= alarm_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display selection
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      relay_msg <= 1'b0;
    else if (clear_latch)
      relay_msg <= 1'b1;
    else if (limits_press || label_cnt == 8'h00)
      relay_msg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      display_label <= pslm_pkg::PSLM_LBL_NONE;
      display_value <= pslm_pkg::ZERO_VAL;
    end
    else
    begin
      display_label <= pslm_pkg::PSLM_LBL_NONE;
      if (relay_msg)
        // R14: relay reset message
        display_label <= pslm_pkg::PSLM_LBL_RELAY_RESET;
      else if (label_cnt != 8'h00)
      begin
        unique case (view)
          pslm_pkg::PSLM_SHOW_RATE: display_label <= pslm_pkg::PSLM_LBL_RATE;
          pslm_pkg::PSLM_SHOW_LIM1: display_label <= pslm_pkg::PSLM_LBL_PROC1;
          pslm_pkg::PSLM_SHOW_LIM2: display_label <= pslm_pkg::PSLM_LBL_PROC2;
          // R11: rate limit label
          pslm_pkg::PSLM_SHOW_LIM3: display_label <= cfg.lim3_is_rate ?
            pslm_pkg::PSLM_LBL_RATE_LIMIT : pslm_pkg::PSLM_LBL_PROC3;
          // R11: deviation label
          pslm_pkg::PSLM_SHOW_LIM4: display_label <= cfg.lim4_is_deviation ?
            pslm_pkg::PSLM_LBL_DEVIATION : pslm_pkg::PSLM_LBL_PROC4;
          pslm_pkg::PSLM_SHOW_TMR1: display_label <= pslm_pkg::PSLM_LBL_TIMER1;
          pslm_pkg::PSLM_SHOW_TMR2: display_label <= pslm_pkg::PSLM_LBL_TIMER2;
          default: display_label <= pslm_pkg::PSLM_LBL_NONE;
        endcase
      end
      // R10: value after label
      unique case (view)
        pslm_pkg::PSLM_SHOW_RATE: display_value <= rate_value;
        pslm_pkg::PSLM_SHOW_LIM1: display_value <= proc_limits[0 +: 24];
        pslm_pkg::PSLM_SHOW_LIM2: display_value <= proc_limits[24 +: 24];
        pslm_pkg::PSLM_SHOW_LIM3: display_value <= proc_limits[48 +: 24];
        pslm_pkg::PSLM_SHOW_LIM4: display_value <= proc_limits[72 +: 24];
        pslm_pkg::PSLM_SHOW_TMR1: display_value <= timer_limits[0 +: 24];
        pslm_pkg::PSLM_SHOW_TMR2: display_value <= timer_limits[24 +: 24];
        default: display_value <= time_view ? elapsed_time : process_value;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== tb/pslm_core_assertions.sv ====
// Checker of the scaling, tare and alarm core, bound to the core.
// Assumes one clock domain and the reset values of the package.
`timescale 1ns/1ns
`default_nettype none
module pslm_core_assertions (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire pslm_pkg::pslm_keys_t keys,
  input wire pslm_pkg::pslm_cfg_t cfg,
  input wire pslm_pkg::pslm_param_wr_t param_wr,
  input wire logic [15:0] high_scale,
  input wire logic [15:0] low_scale,
  input wire logic [23:0] offset_value,
  input wire logic [23:0] process_value,
  input wire logic [4*24-1:0] proc_limits,
  input wire logic [5:0] alarm_active,
  input wire logic [5:0] alarm_out,
  input wire logic [5:0] alarm_led,
  input wire pslm_pkg::pslm_label_t display_label
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  AST_HIGH_RANGE: assert property (
    high_scale >= 16'h0001 && high_scale <= 16'h7530) else $error("high scale out of range");
  AST_LOW_LE_HIGH: assert property (
    low_scale <= high_scale) else $error("low scale above high scale");
  AST_NO_SETUP_HOLD: assert property (
    !cfg.setup_mode |=> $stable(high_scale) && $stable(low_scale) && $stable(offset_value))
    else $error("parameter changed outside setup");
  AST_HIGH_WRITE: assert property (
    cfg.setup_mode && param_wr.wr_high && !param_wr.wr_low && param_wr.wdata >= 24'h000001
    && param_wr.wdata <= 24'h007530 && param_wr.wdata >= {8'h00, low_scale}
    |=> high_scale == $past(param_wr.wdata[15:0])) else $error("high scale write lost");
  AST_OUT_POL: assert property (
    $past(nrst) |-> alarm_out == ($past(alarm_active) ^ $past(cfg.normally_closed)))
    else $error("alarm output polarity wrong");
  AST_LED: assert property (
    $past(nrst) |-> alarm_led == $past(alarm_active)) else $error("indicator wrong");
  AST_PROC_SET: assert property (
    $signed(process_value) >= $signed(proc_limits[23:0]) |=> alarm_active[0])
    else $error("alarm not set at limit");
  AST_PROC_DROP: assert property (
    !cfg.latching[0] && $signed(process_value) < $signed(proc_limits[23:0])
    |=> !alarm_active[0]) else $error("non-latching alarm stuck");
  AST_LATCH_HOLD: assert property (
    !keys.reset_key [*6] ##0 (cfg.latching[1] && alarm_active[1]) |=> alarm_active[1])
    else $error("latched alarm dropped");
  AST_TIMER_CLR: assert property (
    keys.time_key [*4] ##0 $rose(keys.reset_key) |-> ##[1:6] alarm_active[5:4] == 2'b00)
    else $error("timer alarms not cleared");
  AST_RELAY_LABEL: assert property (
    !($past(keys.limits_key, 4) && $past(keys.reset_key, 4))
    |-> !$rose(display_label == pslm_pkg::PSLM_LBL_RELAY_RESET))
    else $error("relay reset shown without limits key");
  cover property (alarm_active[1] ##1 !alarm_active[1]);
  cover property ($fell(alarm_active[4]));
  cover property (display_label == pslm_pkg::PSLM_LBL_DEVIATION);
endmodule
bind pslm_core pslm_core_assertions chk_u (
  .sys_clk, .nrst, .keys, .cfg, .param_wr, .high_scale, .low_scale, .offset_value,
  .process_value, .proc_limits, .alarm_active, .alarm_out, .alarm_led, .display_label
);
`default_nettype wire

// ==== tb/pslm_panel_model.sv ====
// Front keys and remote contact, one pin per bit of the key struct.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
`default_nettype none
module pslm_panel_model (
  input wire logic sys_clk,
  output var pslm_pkg::pslm_keys_t keys
);
  initial keys = '0;
  ////////////////////////////////////////
  // Hold one key down
  task automatic down(input int k);
    @(posedge sys_clk);
    keys[k] <= 1'b1;
    repeat (5) @(posedge sys_clk);
  endtask
  // Let one key go
  task automatic up(input int k);
    @(posedge sys_clk);
    keys[k] <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic press(input int k);
    down(k);
    up(k);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_pslm_core.sv ====
// Self-checking bench of the scaling, tare and alarm core.
// Assumes the panel model drives the keys; label time shortened to 4.
`timescale 1ns/1ns
`default_nettype none
module tb_pslm_core;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  pslm_pkg::pslm_keys_t keys;
  pslm_pkg::pslm_cfg_t cfg = {4'h8, 6'h02, 6'h05};
  pslm_pkg::pslm_param_wr_t param_wr = '0;
  logic sample_valid = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic [15:0] sample_full = 16'h0bb8;
  logic loop_input = 1'b0;
  logic [23:0] elapsed_time = 24'h000000;
  logic [4*24-1:0] proc_limits = {{2{24'h7fffff}}, {2{24'h000064}}};
  logic [2*24-1:0] timer_limits = {24'h7fffff, 24'h0000c8};
  logic [23:0] rate_value = 24'h000123, deviation_value = 24'h000045;
  logic [15:0] high_scale, low_scale;
  logic [23:0] offset_value, tare_value, process_value, display_value;
  logic [3:0] display_label, view;
  logic time_view;
  logic [5:0] alarm_active, alarm_out, alarm_led;
  logic [23:0] corner [5] = '{24'h007530, 24'h007531, 24'h000000, 24'h000bb8, 24'h000bb9};
  int hs = 1, ls = 0, ofs = 0, tr = 0, n_mismatch = 0, checks_done = 0, cyc = 0, p, f;
  logic [31:0] seed = 32'he0d10f0a;
  always #5 sys_clk = ~sys_clk;
  pslm_core #(.LABEL_CYCLES(4)) dut_u (
    .sys_clk, .nrst, .keys, .cfg, .param_wr, .sample_valid, .sample, .sample_full,
    .loop_input, .rate_value, .deviation_value, .elapsed_time,
    .proc_limits, .timer_limits, .high_scale, .low_scale, .offset_value, .tare_value,
    .process_value, .display_value, .display_label, .view, .time_view, .alarm_active,
    .alarm_out, .alarm_led
  );
  pslm_panel_model pm (.sys_clk, .keys);
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [23:0] calc(input int s, input int t);
    int z;
    z = loop_input ? ofs : 0;
    return 24'(ls + (s - z) * (hs - ls) / (int'(sample_full) - z) - (loop_input ? 0 : ofs) - t);
  endfunction
  function automatic logic [23:0] lbl(input int p, input int f);
    case (p)
      1: return pslm_pkg::PSLM_LBL_RATE;
      2: return pslm_pkg::PSLM_LBL_PROC1;
      3: return pslm_pkg::PSLM_LBL_PROC2;
      4: return f ? pslm_pkg::PSLM_LBL_RATE_LIMIT : pslm_pkg::PSLM_LBL_PROC3;
      5: return f ? pslm_pkg::PSLM_LBL_DEVIATION : pslm_pkg::PSLM_LBL_PROC4;
      6: return pslm_pkg::PSLM_LBL_TIMER1;
      default: return pslm_pkg::PSLM_LBL_TIMER2;
    endcase
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] k, input logic [23:0] d);
    @(posedge sys_clk);
    param_wr <= {k, d};
    @(posedge sys_clk);
    param_wr <= '0;
    if (cfg.setup_mode)
    begin
      if (k[3] && d >= pslm_pkg::HIGH_SCALE_MIN && d <= pslm_pkg::HIGH_SCALE_MAX && d >= ls) hs = d;
      if (k[2] && d <= hs) ls = d;
      if (k[1]) ofs = d;
      if (k[0]) tr = d;
    end
    @(posedge sys_clk);
    chk(high_scale, hs);
    chk(low_scale, ls);
    chk(offset_value, ofs);
  endtask
  task automatic smp(input int s);
    @(posedge sys_clk);
    sample <= 16'(s);
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    chk(alarm_out, 24'h000000);
    foreach (corner[i]) wr(i == 4 ? 4'h4 : 4'h8, corner[i]);
    repeat (24)
    begin
      cfg.setup_mode <= (rnd() % 3) != 0;
      wr(4'h4 << rnd() % 2, 24'(rnd() % 32'h8000));
    end
    cfg.setup_mode <= 1'b1;
    wr(4'h4, 24'h000000);
    wr(4'h8, 24'h000bb8);
    wr(4'h2, 24'h000000);
    wr(4'h1, 24'h000000);
    for (p = 0; p < 10; p++)
    begin
      f = p == 0 ? 0 : p == 1 ? 3000 : rnd() % 3001;
      sample_full <= p < 2 ? 16'h0bb8 : 16'h0bb8 + 16'(rnd() % 32'h3e8);
      smp(f);
      chk(process_value, calc(f, tr));
    end
    sample_full <= 16'h0bb8;
    wr(4'h1, 24'h000028);
    smp(16'h0096);
    chk(process_value, calc(16'h0096, tr));
    wr(4'h2, 24'h00000a);
    smp(16'h0096);
    chk(process_value, calc(16'h0096, tr));
    loop_input <= 1'b1;
    wr(4'h4, 24'h0000c8);
    smp(16'h000a);
    chk(process_value, calc(16'h000a, tr));
    smp(16'h0bb8);
    chk(process_value, calc(16'h0bb8, tr));
    loop_input <= 1'b0;
    wr(4'h4, 24'h000000);
    wr(4'h2, 24'h000000);
    smp(16'h0078);
    pm.press(4);
    tr = calc(16'h0078, 0);
    chk(tare_value, tr);
    smp(16'h0078);
    chk(process_value, 24'h000000);
    cfg.setup_mode <= 1'b0;
    cfg.remote_tare_option <= 1'b1;
    pm.down(0);
    smp(16'h012c);
    smp(16'h00fa);
    pm.up(0);
    tr = calc(16'h00fa, 0);
    chk(tare_value, tr);
    smp(16'h0104);
    chk(process_value, calc(16'h0104, tr));
    cfg.remote_tare_option <= 1'b0;
    pm.down(0);
    smp(16'h0384);
    chk(process_value, calc(16'h0104, tr));
    chk(tare_value, tr);
    pm.up(0);
    for (f = 0; f < 2; f++)
    begin
      cfg.lim3_is_rate <= f[0];
      cfg.lim4_is_deviation <= f[0];
      rate_value <= 24'(rnd() % 32'h10000);
      for (p = 1; p < 9; p++)
      begin
        pm.down(3);
        chk(view, p % 8);
        if (p < 8) chk(display_label, lbl(p, f));
        if (p == 1) chk(display_value, rate_value);
        if (p == 2) chk(display_value, 24'h000064);
        pm.up(3);
      end
    end
    chk(display_label, 24'h000000);
    cfg.setup_mode <= 1'b1;
    wr(4'h1, 24'h000000);
    timer_limits[23:0] <= 24'(32'h64 + rnd() % 32'h190);
    elapsed_time <= 24'h0001f4;
    smp(16'h0032);
    chk(alarm_active[5:4], 2'b01);
    pm.down(1);
    chk(time_view, 1'b1);
    chk(display_value, 24'h0001f4);
    elapsed_time <= 24'h000000;
    pm.press(2);
    chk(alarm_active[5:4], 2'b00);
    pm.up(1);
    pm.down(3);
    chk(view, pslm_pkg::PSLM_SHOW_TMR1);
    pm.up(3);
    pm.down(3);
    chk(view, pslm_pkg::PSLM_SHOW_TMR2);
    pm.up(3);
    pm.press(3);
    cfg.normally_closed <= 6'(rnd());
    smp(16'h0096);
    chk(alarm_active[1:0], 2'b11);
    smp(16'h0032);
    chk(alarm_active[1:0], 2'b10);
    chk(alarm_out, 6'h02 ^ cfg.normally_closed);
    chk(alarm_led, 24'h000002);
    pm.press(3);
    pm.press(3);
    pm.down(3);
    pm.down(2);
    chk(display_label, pslm_pkg::PSLM_LBL_RELAY_RESET);
    chk(alarm_active[1], 1'b0);
    pm.up(2);
    pm.up(3);
    proc_limits[95:72] <= 24'h000200;
    deviation_value <= 24'h000300;
    smp(16'h0032);
    chk(alarm_active[3], 1'b1);
    deviation_value <= 24'h000100;
    smp(16'h0032);
    chk(alarm_active[3], 1'b0);
    results();
  end
endmodule
`default_nettype wire
